// ===== design/uasf_consts.svh
`ifndef UASF_CONSTS_SVH
`define UASF_CONSTS_SVH

// Register byte offsets
`define UASF_A_STAT 8'h00
`define UASF_A_CTL1 8'h04
`define UASF_A_CTL2 8'h08
`define UASF_A_DATA 8'h0c
`define UASF_A_BAUD 8'h10
`define UASF_A_RECEIVE_FIFO_COUNT 8'h14
// Control one bits
`define UASF_C1_EN 7
`define UASF_C1_BNO 6
`define UASF_C1_PARITY_ENABLE 5
`define UASF_C1_PTH 4
`define UASF_C1_PTL 3
`define UASF_C1_BRK 2
`define UASF_C1_TX8 0
// Control two bits
`define UASF_C2_TRANSMITTER_ENABLE 7
`define UASF_C2_RECEIVER_ENABLE 6
`define UASF_C2_RIE 2
// Status bits
`define UASF_S_TRANSMIT_EMPTY_FLAG 0
`define UASF_S_TRANSMIT_IDLE_FLAG 1
`define UASF_S_RECEIVE_READY_FLAG 2
// Reset values and counts
`define UASF_BAUD_RST 16'h0010
`define UASF_RX_DEPTH 3'h4
`define UASF_BRK_BITS 4'hd
`define UASF_PT_EVEN 2'h0
`define UASF_PT_ODD 2'h1
`define UASF_PT_MARK 2'h2
`define UASF_PT_SPACE 2'h3
`endif

// ===== design/uasf_pkg.sv
package uasf_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uasf_rx_e;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_BRK} uasf_tx_e;

  typedef struct packed {
    logic act;
    logic wr;
    logic [7:0] addr;
  } uasf_dphase_s;

  typedef struct packed {
    uasf_dphase_s dp;
    logic [31:0] hrdata;
    logic ready;
    logic resp;
    logic global_serial_enable, data_length_select, parity_enable;
    logic [1:0] ptype;
    logic brk, tx8, transmitter_enable, receiver_enable, receive_interrupt_enable;
    logic [15:0] div;
    logic parity_error_flag, nf, framing_error_flag, overrun_error_flag, receive_ready_flag, transmit_idle_flag, transmit_empty_flag;
    logic [7:0] armed;
    logic [3:0][8:0] fifo;
    logic [1:0] rd_ptr;
    logic [2:0] rx_cnt;
    uasf_rx_e rx_st;
    logic [15:0] rx_tmr;
    logic [3:0] rx_bit;
    logic [8:0] rx_sr;
    logic rx_prev, rx_noise;
    uasf_tx_e tx_st;
    logic [15:0] tx_tmr;
    logic [3:0] tx_bit;
    logic [8:0] tx_sr, tx_hold;
    logic hold_full, tx_line, tx_oe_n, irq;
  } uasf_state_s;
endpackage : uasf_pkg

// ===== design/uasf_top.sv
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`include "uasf_consts.svh"
module uasf_top import uasf_pkg::*; #(
  parameter logic [15:0] BAUD_DIV_RST = `UASF_BAUD_RST
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rx_in,
  output logic tx_out,
  output logic tx_oe_n,
  output logic rx_irq
);

  if (BAUD_DIV_RST < 16'h0004) begin : g_chk
    $error("Baud divisor default below 4");
  end

  // ----------------------------------------
  // Parity of the data bits
  // ----------------------------------------
  function automatic logic par_bit(input logic [8:0] d, input logic data_length_select, input logic [1:0] pt);
    logic x;
    x = data_length_select ? ^d[7:0] : ^d[6:0];
    case (pt)
      `UASF_PT_EVEN: par_bit = x;
      `UASF_PT_ODD: par_bit = ~x;
      `UASF_PT_MARK: par_bit = 1'b1;
      default: par_bit = 1'b0;
    endcase
  endfunction : par_bit

  uasf_state_s st_r;
  uasf_state_s st_nxt;
  logic take, rd_stat, rd_data, wr_data, data_acc, push, pop;
  logic [7:0] status;
  logic [8:0] head, rx_word, frame;
  logic [3:0] last_rx, last_tx;
  logic rx_parity_error_flag;

  assign hreadyout = st_r.ready;
  assign hresp = st_r.resp;
  assign hrdata = st_r.hrdata;
  assign tx_out = st_r.tx_line;
  assign tx_oe_n = st_r.tx_oe_n;
  assign rx_irq = st_r.irq;

  always_comb begin
    st_nxt = st_r;
    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    take = hsel & hready & htrans[1];
    rd_stat = take & ~hwrite & (haddr[7:0] == `UASF_A_STAT);
    rd_data = take & ~hwrite & (haddr[7:0] == `UASF_A_DATA);
    wr_data = st_r.dp.act & st_r.dp.wr & (st_r.dp.addr == `UASF_A_DATA);
    data_acc = rd_data | wr_data;
    pop = rd_data & (st_r.rx_cnt != 3'h0);
    push = 1'b0;
    head = st_r.fifo[st_r.rd_ptr];
    last_rx = st_r.data_length_select ? 4'h8 : 4'h7;
    last_tx = last_rx;
    status = {st_r.parity_error_flag, st_r.nf, st_r.framing_error_flag, st_r.overrun_error_flag, st_r.rx_st == RX_IDLE,
              st_r.receive_ready_flag, st_r.transmit_idle_flag, st_r.transmit_empty_flag};
    st_nxt.dp = '{act: take, wr: hwrite, addr: haddr[7:0]};
    st_nxt.ready = 1'b1;
    st_nxt.resp = 1'b0;
    st_nxt.hrdata = 32'h0;
    if (take & ~hwrite) begin
      if (haddr[7:0] == `UASF_A_STAT) begin
        st_nxt.hrdata = {24'h0, status};
      end else if (haddr[7:0] == `UASF_A_CTL1) begin
        // Received ninth bit read-only, transmit ninth reads zero
        // ninth bit access
        st_nxt.hrdata = {24'h0, st_r.global_serial_enable, st_r.data_length_select, st_r.parity_enable, st_r.ptype, st_r.brk, head[8], 1'b0};
      end else if (haddr[7:0] == `UASF_A_CTL2) begin
        st_nxt.hrdata = {24'h0, st_r.transmitter_enable, st_r.receiver_enable, 3'h0, st_r.receive_interrupt_enable, 2'h0};
      end else if (haddr[7:0] == `UASF_A_DATA) begin
        st_nxt.hrdata = {24'h0, head[7:0]};
      end else if (haddr[7:0] == `UASF_A_BAUD) begin
        st_nxt.hrdata = {16'h0, st_r.div};
      end else if (haddr[7:0] == `UASF_A_RECEIVE_FIFO_COUNT) begin
        st_nxt.hrdata = {29'h0, st_r.rx_cnt};
      end
    end
    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    if (st_r.dp.act & st_r.dp.wr) begin
      if (st_r.dp.addr == `UASF_A_CTL1) begin
        st_nxt.global_serial_enable = hwdata[`UASF_C1_EN];
        st_nxt.data_length_select = hwdata[`UASF_C1_BNO];
        st_nxt.parity_enable = hwdata[`UASF_C1_PARITY_ENABLE];
        st_nxt.ptype = hwdata[`UASF_C1_PTH:`UASF_C1_PTL];
        st_nxt.brk = hwdata[`UASF_C1_BRK];
        st_nxt.tx8 = hwdata[`UASF_C1_TX8];
      end else if (st_r.dp.addr == `UASF_A_CTL2) begin
        st_nxt.transmitter_enable = hwdata[`UASF_C2_TRANSMITTER_ENABLE];
        st_nxt.receiver_enable = hwdata[`UASF_C2_RECEIVER_ENABLE];
        st_nxt.receive_interrupt_enable = hwdata[`UASF_C2_RIE];
        if (hwdata[`UASF_C2_TRANSMITTER_ENABLE] & ~st_r.transmitter_enable) begin
          st_nxt.transmit_empty_flag = 1'b1;
        end
      end else if (st_r.dp.addr == `UASF_A_BAUD) begin
        st_nxt.div = hwdata[15:0];
      end else if (st_r.dp.addr == `UASF_A_DATA) begin
        st_nxt.tx_hold = {st_r.tx8, hwdata[7:0]};
        st_nxt.hold_full = 1'b1;
      end
    end
    // ----------------------------------------
    // Armed clear sequences
    // ----------------------------------------
    // arm on status read
    if (data_acc) begin
      st_nxt.armed = 8'h0;
      {st_nxt.parity_error_flag, st_nxt.nf, st_nxt.framing_error_flag, st_nxt.overrun_error_flag} =
        {st_r.parity_error_flag, st_r.nf, st_r.framing_error_flag, st_r.overrun_error_flag} & ~st_r.armed[7:4];
    end
    if (rd_stat) begin
      st_nxt.armed = status;
    end
    if (wr_data & st_r.armed[`UASF_S_TRANSMIT_EMPTY_FLAG]) begin
      st_nxt.transmit_empty_flag = 1'b0;
    end
    if (wr_data & st_r.armed[`UASF_S_TRANSMIT_IDLE_FLAG]) begin
      st_nxt.transmit_idle_flag = 1'b0;
    end
    if (pop) begin
      st_nxt.rd_ptr = st_r.rd_ptr + 2'h1;
    end
    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    st_nxt.rx_prev = rx_in;
    rx_word = st_r.rx_sr;
    rx_word[8] = st_r.data_length_select & ~st_r.parity_enable & st_r.rx_sr[8];
    rx_word[7] = (st_r.data_length_select | ~st_r.parity_enable) & st_r.rx_sr[7];
    rx_parity_error_flag = st_r.parity_enable & (par_bit(st_r.rx_sr, st_r.data_length_select, st_r.ptype) != st_r.rx_sr[last_rx]);
    st_nxt.rx_tmr = st_r.rx_tmr - 16'h0001;
    case (st_r.rx_st)
      RX_IDLE: begin
        if (~rx_in) begin
          st_nxt.rx_st = RX_START;
          st_nxt.rx_tmr = st_r.div >> 1;
        end
      end
      RX_START: begin
        if (st_r.rx_tmr == 16'h0) begin
          st_nxt.rx_st = rx_in ? RX_IDLE : RX_DATA;
          st_nxt.rx_tmr = st_r.div - 16'h0001;
          st_nxt.rx_bit = 4'h0;
          st_nxt.rx_noise = 1'b0;
        end
      end
      RX_DATA: begin
        if (st_r.rx_tmr == 16'h0) begin
          st_nxt.rx_sr[st_r.rx_bit] = rx_in;
          st_nxt.rx_noise = st_r.rx_noise | (rx_in != st_r.rx_prev);
          st_nxt.rx_tmr = st_r.div - 16'h0001;
          st_nxt.rx_bit = st_r.rx_bit + 4'h1;
          if (st_r.rx_bit == last_rx) begin
            st_nxt.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (st_r.rx_tmr == 16'h0) begin
          st_nxt.rx_st = RX_IDLE;
          push = 1'b1;
        end
      end
      default: st_nxt.rx_st = RX_IDLE;
    endcase
    st_nxt.rx_cnt = st_r.rx_cnt - {2'h0, pop};
    if (rd_data & st_r.armed[`UASF_S_RECEIVE_READY_FLAG] & (st_nxt.rx_cnt == 3'h0)) begin
      st_nxt.receive_ready_flag = 1'b0;
    end
    if (push & ~st_r.overrun_error_flag) begin
      if (st_r.rx_cnt == `UASF_RX_DEPTH) begin
        st_nxt.overrun_error_flag = 1'b1;
      end else begin
        st_nxt.fifo[st_r.rd_ptr + st_r.rx_cnt[1:0]] = rx_word;
        st_nxt.rx_cnt = st_nxt.rx_cnt + 3'h1;
        st_nxt.receive_ready_flag = 1'b1;
        st_nxt.framing_error_flag = st_nxt.framing_error_flag | ~rx_in;
        st_nxt.parity_error_flag = st_nxt.parity_error_flag | rx_parity_error_flag;
        st_nxt.nf = st_nxt.nf | st_r.rx_noise | (rx_in != st_r.rx_prev);
      end
    end
    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    frame = st_r.tx_hold;
    if (st_r.parity_enable) begin
      frame[last_tx] = par_bit(st_r.tx_hold, st_r.data_length_select, st_r.ptype);
    end
    st_nxt.tx_tmr = st_r.tx_tmr - 16'h0001;
    case (st_r.tx_st)
      TX_IDLE: begin
        st_nxt.tx_line = 1'b1;
        if (st_r.hold_full) begin
          st_nxt.tx_sr = frame;
          st_nxt.hold_full = 1'b0;
          st_nxt.transmit_empty_flag = 1'b1;
          st_nxt.tx_st = TX_START;
          st_nxt.tx_tmr = st_r.div - 16'h0001;
          st_nxt.tx_line = 1'b0;
        end else if (st_r.brk) begin
          st_nxt.tx_st = TX_BRK;
          st_nxt.tx_bit = 4'h0;
          st_nxt.tx_tmr = st_r.div - 16'h0001;
          st_nxt.tx_line = 1'b0;
        end
      end
      TX_START: begin
        if (st_r.tx_tmr == 16'h0) begin
          st_nxt.tx_st = TX_DATA;
          st_nxt.tx_bit = 4'h0;
          st_nxt.tx_line = st_r.tx_sr[0];
          st_nxt.tx_tmr = st_r.div - 16'h0001;
        end
      end
      TX_DATA: begin
        if (st_r.tx_tmr == 16'h0) begin
          st_nxt.tx_tmr = st_r.div - 16'h0001;
          if (st_r.tx_bit == last_tx) begin
            st_nxt.tx_st = TX_STOP;
            st_nxt.tx_line = 1'b1;
          end else begin
            st_nxt.tx_bit = st_r.tx_bit + 4'h1;
            st_nxt.tx_line = st_r.tx_sr[st_r.tx_bit + 4'h1];
          end
        end
      end
      TX_STOP: begin
        if (st_r.tx_tmr == 16'h0) begin
          st_nxt.tx_st = TX_IDLE;
        end
      end
      TX_BRK: begin
        st_nxt.tx_line = 1'b0;
        if (st_r.tx_tmr == 16'h0) begin
          st_nxt.tx_tmr = st_r.div - 16'h0001;
          if (st_r.tx_bit < `UASF_BRK_BITS) begin
            st_nxt.tx_bit = st_r.tx_bit + 4'h1;
          end
        end
        if ((st_r.tx_bit >= `UASF_BRK_BITS) & ~st_r.brk) begin
          st_nxt.tx_st = TX_IDLE;
          st_nxt.tx_line = 1'b1;
        end
      end
      default: st_nxt.tx_st = TX_IDLE;
    endcase
    // ----------------------------------------
    // Enables and disable effects
    // ----------------------------------------
    if (~st_r.receiver_enable | ~st_nxt.global_serial_enable) begin
      st_nxt.rx_st = RX_IDLE;
      st_nxt.rx_cnt = 3'h0;
      st_nxt.rd_ptr = 2'h0;
    end
    if (~st_r.transmitter_enable | ~st_nxt.global_serial_enable) begin
      st_nxt.tx_st = TX_IDLE;
      st_nxt.hold_full = 1'b0;
      st_nxt.tx_line = 1'b1;
    end
    if (~st_nxt.global_serial_enable) begin
      {st_nxt.transmitter_enable, st_nxt.receiver_enable, st_nxt.brk, st_nxt.receive_ready_flag} = 4'h0;
      {st_nxt.overrun_error_flag, st_nxt.framing_error_flag, st_nxt.parity_error_flag, st_nxt.nf} = 4'h0;
      {st_nxt.transmit_empty_flag, st_nxt.transmit_idle_flag} = 2'h3;
      st_nxt.rx_tmr = 16'h0;
      st_nxt.tx_tmr = 16'h0;
    end
    if (st_nxt.transmit_empty_flag & (st_nxt.tx_st == TX_IDLE) & ~st_nxt.hold_full & ~st_nxt.brk) begin
      st_nxt.transmit_idle_flag = 1'b1;
    end
    if (~st_nxt.transmit_empty_flag | (st_nxt.tx_st != TX_IDLE)) begin
      st_nxt.transmit_idle_flag = 1'b0;
    end
    st_nxt.tx_oe_n = ~(st_nxt.global_serial_enable & st_nxt.transmitter_enable);
    st_nxt.irq = st_nxt.receive_ready_flag & st_nxt.receive_interrupt_enable;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.ready <= 1'b1;
      st_r.div <= BAUD_DIV_RST;
      st_r.transmit_empty_flag <= 1'b1;
      st_r.transmit_idle_flag <= 1'b1;
      st_r.tx_line <= 1'b1;
      st_r.tx_oe_n <= 1'b1;
      st_r.rx_prev <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_arm_tx;
    rd_stat && st_r.transmit_empty_flag && !st_r.transmit_idle_flag;
  endsequence
  sequence s_wr_clear;
    wr_data && st_r.tx_st != TX_IDLE && st_r.global_serial_enable && st_r.transmitter_enable;
  endsequence

  property p_ovr_block;
    st_r.overrun_error_flag |=> st_r.rx_cnt <= $past(st_r.rx_cnt);
  endproperty
  a_ovr_block: assert property (p_ovr_block) else $error("Receive count grew during overrun");

  property p_rx_busy;
    st_r.global_serial_enable && st_r.receiver_enable && st_r.rx_st == RX_IDLE && !rx_in ##1 st_r.global_serial_enable |-> !status[3];
  endproperty
  a_rx_busy: assert property (p_rx_busy) else $error("Receiver idle high after start");

  property p_err_with_ready;
    $rose(st_r.framing_error_flag) |-> st_r.receive_ready_flag && $past(push);
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("Framing flag set without word");

  property p_ready_holds;
    st_r.receive_ready_flag && st_r.rx_cnt > 3'h1 && st_r.global_serial_enable && st_r.receiver_enable |=> st_r.receive_ready_flag || !st_r.global_serial_enable;
  endproperty
  a_ready_holds: assert property (p_ready_holds) else $error("Receive ready cleared with data left");

  property p_idle_needs_empty;
    st_r.transmit_idle_flag |-> st_r.transmit_empty_flag && st_r.tx_line;
  endproperty
  a_idle_needs_empty: assert property (p_idle_needs_empty) else $error("Transmit idle without empty");

  property p_arm_clear;
    s_arm_tx ##1 !rd_data ##2 s_wr_clear |=> !st_r.transmit_empty_flag;
  endproperty
  a_arm_clear: assert property (p_arm_clear) else $error("Armed write left empty flag set");

  property p_transmitter_enable_empty;
    $rose(st_r.transmitter_enable) |-> st_r.transmit_empty_flag;
  endproperty
  a_transmitter_enable_empty: assert property (p_transmitter_enable_empty) else $error("Enable did not set empty flag");

  property p_disable;
    !st_r.global_serial_enable |-> !st_r.transmitter_enable && !st_r.receive_ready_flag && !st_r.overrun_error_flag && st_r.transmit_empty_flag && st_r.transmit_idle_flag
      && st_r.rx_cnt == 3'h0 && st_r.tx_oe_n;
  endproperty
  a_disable: assert property (p_disable) else $error("Disable state incomplete");

  property p_brk_low;
    st_r.tx_st == TX_BRK && st_r.tx_bit < `UASF_BRK_BITS && st_r.global_serial_enable && st_r.transmitter_enable
      |=> (st_r.tx_st == TX_BRK && !st_r.tx_line) || !st_r.global_serial_enable || !st_r.transmitter_enable;
  endproperty
  a_brk_low: assert property (p_brk_low) else $error("Break ended too early");

endmodule : uasf_top

// ===== test/uasf_remote.sv
`timescale 1ns/1ps
// ----------------------------------------
// Remote serial transceiver
// ----------------------------------------
module uasf_remote #(
  parameter int DIV = 8
) (
  input wire logic clk,
  output logic line_out,
  input wire logic line_in
);
  initial line_out = 1'b1;

  task automatic send(input logic [8:0] w, input int nb, input logic stp);
    int i;
    line_out <= 1'b0;
    repeat (DIV) @(posedge clk);
    for (i = 0; i < nb; i++) begin
      line_out <= w[i];
      repeat (DIV) @(posedge clk);
    end
    line_out <= stp;
    repeat (DIV) @(posedge clk);
    line_out <= 1'b1;
    repeat (DIV) @(posedge clk);
  endtask : send

  task automatic recv(input int nb, output logic [8:0] w, output logic ok);
    int n;
    w = 9'h0;
    n = 0;
    while (line_in !== 1'b0 && n < 100 * DIV) begin
      @(posedge clk);
      n++;
    end
    ok = (n < 100 * DIV);
    repeat (DIV / 2) @(posedge clk);
    for (n = 0; n < nb; n++) begin
      repeat (DIV) @(posedge clk);
      w[n] = line_in;
    end
    repeat (DIV) @(posedge clk);
    if (line_in !== 1'b1) ok = 1'b0;
  endtask : recv
endmodule : uasf_remote

// ===== test/uasf_top_test.sv
`timescale 1ns/1ps
`include "uasf_consts.svh"
module uasf_top_test;
  localparam int DIV = 8;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, tx_out, tx_oe_n, rx_irq, rx_in, line_tx, ok;
  logic [31:0] hrdata;
  logic [8:0] w;
  int failures = 0;
  int checked = 0;
  int i, n;

  always #5 hclk = ~hclk;
  // Pull-up on the transmit wire
  assign line_tx = tx_oe_n ? 1'b1 : tx_out;

  uasf_top i_uasf_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .rx_in(rx_in), .tx_out(tx_out), .tx_oe_n(tx_oe_n), .rx_irq(rx_irq));
  uasf_remote #(.DIV(DIV)) i_uasf_remote (.clk(hclk), .line_out(rx_in), .line_in(line_tx));

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic close_out;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic xfer(input logic wr_n, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr_n;
    haddr <= {24'h0, a};
    k = 0;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 100);
    q = hrdata;
    if (k >= 100) begin
      failures++;
      close_out();
    end
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd

  task automatic rx_case(input logic [7:0] c1, input logic [8:0] wd, input int nb, input logic stp,
      input logic [31:0] st, input logic [31:0] c1r, input logic [31:0] dat);
    wr(`UASF_A_CTL1, {24'h0, c1});
    i_uasf_remote.send(wd, nb, stp);
    rd(`UASF_A_STAT, st);
    chk({31'h0, rx_irq}, 32'h1);
    rd(`UASF_A_CTL1, c1r);
    rd(`UASF_A_DATA, dat);
    rd(`UASF_A_STAT, 32'h0b);
  endtask : rx_case

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    close_out();
  end

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`UASF_A_STAT, 32'h0b);
    rd(`UASF_A_CTL1, 32'h0);
    rd(8'h1c, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    chk({31'h0, hreadyout}, 32'h1);
    wr(`UASF_A_BAUD, DIV);
    wr(`UASF_A_CTL1, 32'h80);
    wr(`UASF_A_CTL2, 32'h44);
    chk({31'h0, tx_oe_n}, 32'h1);
    rd(`UASF_A_STAT, 32'h0b);
    wr(`UASF_A_DATA, 32'h5a);
    rd(`UASF_A_STAT, 32'h08);
    wr(`UASF_A_CTL2, 32'hc4);
    @(posedge hclk);
    chk({31'h0, tx_oe_n}, 32'h0);
    rd(`UASF_A_STAT, 32'h0b);
    fork
      i_uasf_remote.send(9'h03c, 8, 1'b1);
      begin
        repeat (3 * DIV) @(posedge hclk);
        rd(`UASF_A_STAT, 32'h03);
      end
    join
    rd(`UASF_A_STAT, 32'h0f);
    rd(`UASF_A_DATA, 32'h3c);
    rd(`UASF_A_STAT, 32'h0b);
    rx_case(8'h80, 9'h055, 8, 1'b0, 32'h2f, 32'h80, 32'h55);
    rx_case(8'ha0, 9'h001, 8, 1'b1, 32'h8f, 32'ha0, 32'h01);
    rx_case(8'ha8, 9'h001, 8, 1'b1, 32'h0f, 32'ha8, 32'h01);
    rx_case(8'hb0, 9'h001, 8, 1'b1, 32'h8f, 32'hb0, 32'h01);
    rx_case(8'hb8, 9'h001, 8, 1'b1, 32'h0f, 32'hb8, 32'h01);
    rx_case(8'hc0, 9'h1a5, 9, 1'b1, 32'h0f, 32'hc2, 32'ha5);
    rx_case(8'he0, 9'h10f, 9, 1'b1, 32'h8f, 32'he0, 32'h0f);
    for (i = 0; i < 4; i++) begin
      wr(`UASF_A_CTL1, 32'ha0 | (32'(i) << 3));
      rd(`UASF_A_STAT, 32'h0b);
      wr(`UASF_A_DATA, 32'h35);
      i_uasf_remote.recv(8, w, ok);
      chk({ok, w}, {1'b1, 1'b0, (i == 0) ? ^7'h35 : (i == 1) ? ~^7'h35 : (i == 2), 7'h35});
      repeat (DIV) @(posedge hclk);
      rd(`UASF_A_STAT, 32'h0b);
    end
    wr(`UASF_A_CTL1, 32'hc1);
    rd(`UASF_A_STAT, 32'h0b);
    wr(`UASF_A_DATA, 32'h35);
    fork
      begin
        i_uasf_remote.recv(9, w, ok);
        chk({ok, w}, 32'h335);
      end
      begin
        repeat (2) @(posedge hclk);
        rd(`UASF_A_STAT, 32'h09);
        wr(`UASF_A_DATA, 32'h36);
        rd(`UASF_A_STAT, 32'h08);
      end
    join
    i_uasf_remote.recv(9, w, ok);
    chk({ok, w}, 32'h336);
    wr(`UASF_A_CTL1, 32'h84);
    for (i = 0; i < 4 * DIV && line_tx !== 1'b0; i++) @(posedge hclk);
    n = 0;
    for (i = 0; i < 14 * DIV; i++) begin
      @(posedge hclk);
      n += (line_tx === 1'b0);
    end
    chk(n, 14 * DIV);
    wr(`UASF_A_CTL1, 32'h80);
    repeat (2 * DIV) @(posedge hclk);
    chk({31'h0, line_tx}, 32'h1);
    for (i = 0; i < 5; i++) i_uasf_remote.send(9'h011 + 9'(i), 8, 1'b1);
    rd(`UASF_A_RECEIVE_FIFO_COUNT, 32'h4);
    rd(`UASF_A_STAT, 32'h1f);
    rd(`UASF_A_DATA, 32'h11);
    rd(`UASF_A_STAT, 32'h0f);
    rd(`UASF_A_RECEIVE_FIFO_COUNT, 32'h3);
    wr(`UASF_A_CTL1, 32'h60);
    rd(`UASF_A_STAT, 32'h0b);
    rd(`UASF_A_CTL1, 32'h60);
    rd(`UASF_A_CTL2, 32'h04);
    rd(`UASF_A_RECEIVE_FIFO_COUNT, 32'h0);
    rd(`UASF_A_BAUD, DIV);
    chk({31'h0, tx_oe_n}, 32'h1);
    close_out();
  end
endmodule : uasf_top_test
